/* fault_regs.svh */
// Operation
// - Handler control bits 18..16 enable usage, bus and memory fault handlers.
// - Bits 15..12 show supervisor call, bus, memory, usage pending; writes change them.
// - Bits 11,10,8,7,3,1,0 show active exceptions; writes change them.
// - A fault whose handler is disabled is taken as a hard fault.
// - Combined status decodes word, byte and halfword views at its three addresses.
// - Memory status bit 7 is 1 only while the fault address is valid.
// - Memory bit 4 set on stacking violation; no address captured.
// - Memory bit 3 set on unstacking violation; no address captured.
// - Memory bit 1 set on data access violation; address is captured.
// - Memory bit 0 set on fetch from no-execute region; no address captured.
// - Bus bit 7 set after addressed bus fault; later memory fault clears it.
// - Bus bit 4 set on stacking bus fault; no address captured.
// - Bus bit 3 set on unstacking bus fault; no address captured.
// - Bus bit 2 flags async data error; stays pending while priority blocks it.
// - A precise fault before the async handler leaves both flags set.
// - Bus bit 1 set on precise data error; address is captured.
// - Bus bit 0 set only when the faulting prefetched instruction issues.
// - Status flags other than bus bit 7 stay set until software writes 1 or reset.
`ifndef FAULT_REGS_SVH
`define FAULT_REGS_SVH

// ==========================================================
// Addresses
`define STATUS_ADDR      32'hE000ED28
`define MEM_STATUS_ADDR  32'hE000ED28
`define BUS_STATUS_ADDR  32'hE000ED29
`define USE_STATUS_ADDR  32'hE000ED2A
`define HCS_ADDR         32'hE000ED24

// ==========================================================
// Handler control field positions
`define HCS_USE_ENA      18
`define HCS_BUS_ENA      17
`define HCS_MEM_ENA      16
`define HCS_PEND_LSB     12
`define HCS_WRITE_MASK   32'h0007FD8B

// ==========================================================
// Status field positions and masks
`define ADDR_VALID_BIT   7
`define STK_BIT          4
`define UNSTK_BIT        3
`define ASYNC_BIT        2
`define PRECISE_BIT      1
`define FETCH_BIT        0
`define MEM_FLAG_MASK    8'h1B
`define BUS_FLAG_MASK    8'h1F
`define USE_FLAG_MASK    16'h030F
`define RESET_VALUE      32'h00000000

`endif

/* fault_pkg.sv */
package fault_pkg;
  typedef enum logic [1:0] {
    SZ_BYTE = 2'h0,
    SZ_HALF = 2'h1,
    SZ_WORD = 2'h2
  } access_size_e;

  typedef logic [3:0] lane_t;
endpackage

/* fault_flag_bank.sv */
`timescale 1ns/1ps
module fault_flag_bank #(
  parameter int               WIDTH     = 8,
  parameter logic [WIDTH-1:0] IMPL_MASK = '1
) (
  // Clock and reset
  input  wire logic             clk_i,
  input  wire logic             rstn_i,
  // Hardware set, software write-one clear
  input  wire logic [WIDTH-1:0] set_i,
  input  wire logic [WIDTH-1:0] clr_i,
  // Flags
  output logic      [WIDTH-1:0] flags_o
);
  // ==========================================================
  // One sticky bit per implemented position
  for (genvar i = 0; i < WIDTH; i++)
  begin : g_bit
    if (IMPL_MASK[i])
    begin : g_impl
      logic bit_q;
      always_ff @(posedge clk_i or negedge rstn_i)
      begin
        if (!rstn_i)
          bit_q <= 1'b0;
        else
          bit_q <= (bit_q & ~clr_i[i]) | set_i[i];
      end
      assign flags_o[i] = bit_q;
    end
    else
    begin : g_resv
      assign flags_o[i] = 1'b0;
    end
  end
endmodule // fault_flag_bank

/* fault_route.sv */
`timescale 1ns/1ps
module fault_route (
  // Handler enables
  input  wire logic mem_ena_i,
  input  wire logic bus_ena_i,
  input  wire logic use_ena_i,
  // Fault events
  input  wire logic mem_evt_i,
  input  wire logic bus_sync_evt_i,
  input  wire logic bus_async_evt_i,
  input  wire logic use_evt_i,
  input  wire logic prio_block_i,
  // Routing
  output logic      mem_pend_o,
  output logic      bus_pend_o,
  output logic      use_pend_o,
  output logic      hard_o
);
  logic mem_hard;
  logic bus_hard;
  logic use_hard;

  // ==========================================================
  // Disabled or priority-blocked synchronous faults escalate
  always_comb
  begin
    mem_hard   = mem_evt_i & (~mem_ena_i | prio_block_i);
    bus_hard   = (bus_sync_evt_i & (~bus_ena_i | prio_block_i))
               | (bus_async_evt_i & ~bus_ena_i);
    use_hard   = use_evt_i & (~use_ena_i | prio_block_i);
    mem_pend_o = mem_evt_i & ~mem_hard;
    // Async error waits pending while priority blocks it
    bus_pend_o = (bus_sync_evt_i | bus_async_evt_i) & ~bus_hard;
    use_pend_o = use_evt_i & ~use_hard;
    hard_o     = mem_hard | bus_hard | use_hard;
  end
endmodule // fault_route

/* system_fault_status_control.sv */
`timescale 1ns/1ps
`include "fault_regs.svh"
module system_fault_status_control (
  // Clock and reset
  input  wire logic                  clk_i,
  input  wire logic                  rstn_i,
  // Register access
  input  wire logic                  req_i,
  input  wire logic                  we_i,
  input  wire logic [31:0]           addr_i,
  input  wire fault_pkg::access_size_e size_i,
  input  wire logic [31:0]           wdata_i,
  output logic      [31:0]           rdata_o,
  output logic                       ack_o,
  output logic                       err_o,
  // Memory fault events
  input  wire logic                  memory_stacking_error_i,
  input  wire logic                  memory_unstacking_error_i,
  input  wire logic                  data_access_violation_i,
  input  wire logic                  fetch_access_violation_i,
  // Bus fault events
  input  wire logic                  bus_stacking_error_i,
  input  wire logic                  bus_unstacking_error_i,
  input  wire logic                  async_data_bus_error_i,
  input  wire logic                  sync_data_bus_error_i,
  input  wire logic                  fetch_bus_error_i,
  input  wire logic                  fetch_issue_i,
  // Usage fault events
  input  wire logic [15:0]           usage_cause_i,
  // Exception state from the pipeline
  input  wire logic                  prio_block_i,
  input  wire logic                  supervisor_call_pend_i,
  input  wire logic [3:0]            pend_clr_i,
  input  wire logic [6:0]            act_set_i,
  input  wire logic [6:0]            act_clr_i,
  // Handler state
  output logic                       usage_fault_enable_o,
  output logic                       bus_fault_enable_o,
  output logic                       memory_fault_enable_o,
  output logic      [3:0]            pending_o,
  output logic      [6:0]            active_o,
  output logic                       hard_fault_o,
  output logic                       memory_address_capture_o,
  output logic                       bus_address_capture_o
);
  import fault_pkg::*;

  // ==========================================================
  // Access decode
  lane_t       lanes;
  logic        aligned;
  logic        hit_status;
  logic        hit_hcs;
  logic        wr_status;
  logic        wr_hcs;
  logic [31:0] lane_mask;

  always_comb
  begin
    unique case (size_i)
      SZ_BYTE: lanes = lane_t'(4'h1 << addr_i[1:0]);
      SZ_HALF: lanes = addr_i[1] ? 4'hC : 4'h3;
      SZ_WORD: lanes = 4'hF;
      default: lanes = 4'h0;
    endcase
    unique case (size_i)
      SZ_BYTE: aligned = 1'b1;
      SZ_HALF: aligned = ~addr_i[0];
      SZ_WORD: aligned = addr_i[1:0] == 2'h0;
      default: aligned = 1'b0;
    endcase
  end

  // Word, byte and halfword views of the combined status
  assign hit_status = ({addr_i[31:2], 2'h0} == `STATUS_ADDR) && aligned;
  assign hit_hcs    = (addr_i == `HCS_ADDR) && (size_i == SZ_WORD);
  assign wr_status  = req_i & we_i & hit_status;
  assign wr_hcs     = req_i & we_i & hit_hcs;
  assign lane_mask  = {{8{lanes[3]}}, {8{lanes[2]}}, {8{lanes[1]}}, {8{lanes[0]}}};

  logic [31:0] clr_bits;
  assign clr_bits = wr_status ? (wdata_i & lane_mask) : 32'h0;

  // ==========================================================
  // Fault routing
  logic mem_evt;
  logic bus_sync_evt;
  logic fetch_bus_evt;
  logic use_evt;
  logic mem_pend_set;
  logic bus_pend_set;
  logic use_pend_set;
  logic hard_evt;

  assign fetch_bus_evt = fetch_bus_error_i & fetch_issue_i;
  assign mem_evt       = memory_stacking_error_i | memory_unstacking_error_i
                       | data_access_violation_i | fetch_access_violation_i;
  assign bus_sync_evt  = bus_stacking_error_i | bus_unstacking_error_i
                       | sync_data_bus_error_i | fetch_bus_evt;
  assign use_evt       = |(usage_cause_i & `USE_FLAG_MASK);

  fault_route u_route (
    .mem_ena_i       (memory_fault_enable_o),
    .bus_ena_i       (bus_fault_enable_o),
    .use_ena_i       (usage_fault_enable_o),
    .mem_evt_i       (mem_evt),
    .bus_sync_evt_i  (bus_sync_evt),
    .bus_async_evt_i (async_data_bus_error_i),
    .use_evt_i       (use_evt),
    .prio_block_i    (prio_block_i),
    .mem_pend_o      (mem_pend_set),
    .bus_pend_o      (bus_pend_set),
    .use_pend_o      (use_pend_set),
    .hard_o          (hard_evt)
  );

  // ==========================================================
  // Sticky cause flags
  logic [7:0]  mem_set;
  logic [7:0]  bus_set;
  logic [7:0]  mem_flags;
  logic [7:0]  bus_flags;
  logic [15:0] use_flags;

  always_comb
  begin
    mem_set                = 8'h00;
    mem_set[`STK_BIT]      = memory_stacking_error_i;
    mem_set[`UNSTK_BIT]    = memory_unstacking_error_i;
    mem_set[`PRECISE_BIT]  = data_access_violation_i;
    mem_set[`FETCH_BIT]    = fetch_access_violation_i;
    bus_set                = 8'h00;
    bus_set[`STK_BIT]      = bus_stacking_error_i;
    bus_set[`UNSTK_BIT]    = bus_unstacking_error_i;
    bus_set[`ASYNC_BIT]    = async_data_bus_error_i;
    bus_set[`PRECISE_BIT]  = sync_data_bus_error_i;
    bus_set[`FETCH_BIT]    = fetch_bus_evt;
  end

  // Async and precise flags are independent bits, so both can stand
  fault_flag_bank #(
    .WIDTH     (8),
    .IMPL_MASK (`MEM_FLAG_MASK)
  ) u_mem_flags (
    .clk_i   (clk_i),
    .rstn_i  (rstn_i),
    .set_i   (mem_set),
    .clr_i   (clr_bits[7:0]),
    .flags_o (mem_flags)
  );

  fault_flag_bank #(
    .WIDTH     (8),
    .IMPL_MASK (`BUS_FLAG_MASK)
  ) u_bus_flags (
    .clk_i   (clk_i),
    .rstn_i  (rstn_i),
    .set_i   (bus_set),
    .clr_i   (clr_bits[15:8]),
    .flags_o (bus_flags)
  );

  fault_flag_bank #(
    .WIDTH     (16),
    .IMPL_MASK (`USE_FLAG_MASK)
  ) u_use_flags (
    .clk_i   (clk_i),
    .rstn_i  (rstn_i),
    .set_i   (usage_cause_i),
    .clr_i   (clr_bits[31:16]),
    .flags_o (use_flags)
  );

  // ==========================================================
  // Address-valid flags
  logic mem_valid_q;
  logic bus_valid_q;

  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      mem_valid_q <= 1'b0;
    else if (data_access_violation_i)
      mem_valid_q <= 1'b1;
    else if (clr_bits[`ADDR_VALID_BIT])
      mem_valid_q <= 1'b0;
  end

  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      bus_valid_q <= 1'b0;
    else if (sync_data_bus_error_i)
      bus_valid_q <= 1'b1;
    else if (mem_evt || clr_bits[8 + `ADDR_VALID_BIT])
      bus_valid_q <= 1'b0;
  end

  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      memory_address_capture_o <= 1'b0;
      bus_address_capture_o    <= 1'b0;
    end
    else
    begin
      memory_address_capture_o <= data_access_violation_i;
      bus_address_capture_o    <= sync_data_bus_error_i;
    end
  end

  // ==========================================================
  // Handler enables
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      usage_fault_enable_o  <= 1'b0;
      bus_fault_enable_o    <= 1'b0;
      memory_fault_enable_o <= 1'b0;
    end
    else if (wr_hcs)
    begin
      usage_fault_enable_o  <= wdata_i[`HCS_USE_ENA];
      bus_fault_enable_o    <= wdata_i[`HCS_BUS_ENA];
      memory_fault_enable_o <= wdata_i[`HCS_MEM_ENA];
    end
  end

  // ==========================================================
  // Pending and active state; hardware set wins over any clear
  logic [3:0] pend_set;
  assign pend_set = {supervisor_call_pend_i, bus_pend_set, mem_pend_set, use_pend_set};

  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      pending_o <= 4'h0;
    else if (wr_hcs)
      pending_o <= wdata_i[15:12] | pend_set;
    else
      pending_o <= (pending_o & ~pend_clr_i) | pend_set;
  end

  logic [6:0] act_wdata;
  assign act_wdata = {wdata_i[11:10], wdata_i[8:7], wdata_i[3], wdata_i[1:0]};

  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      active_o <= 7'h00;
    else if (wr_hcs)
      active_o <= act_wdata | act_set_i;
    else
      active_o <= (active_o & ~act_clr_i) | act_set_i;
  end

  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      hard_fault_o <= 1'b0;
    else
      hard_fault_o <= hard_evt;
  end

  // ==========================================================
  // Read data and answer
  logic [31:0] status_word;
  logic [31:0] hcs_word;
  logic [31:0] rdata_d;

  assign status_word = {use_flags, bus_valid_q, bus_flags[6:0], mem_valid_q, mem_flags[6:0]};
  // Whole word returned so software can read, modify and write
  assign hcs_word = {13'h0000, usage_fault_enable_o, bus_fault_enable_o,
                     memory_fault_enable_o, pending_o, active_o[6:5], 1'b0,
                     active_o[4:3], 3'h0, active_o[2], 1'b0, active_o[1:0]};

  always_comb
  begin
    rdata_d = `RESET_VALUE;
    if (req_i && !we_i && hit_status)
      rdata_d = status_word & lane_mask;
    else if (req_i && !we_i && hit_hcs)
      rdata_d = hcs_word & `HCS_WRITE_MASK;
  end

  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      rdata_o <= `RESET_VALUE;
      ack_o   <= 1'b0;
      err_o   <= 1'b0;
    end
    else
    begin
      rdata_o <= rdata_d;
      ack_o   <= req_i;
      err_o   <= req_i & ~hit_status & ~hit_hcs;
    end
  end

  // ==========================================================
  // Checks
  enable_write_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    wr_hcs |=> bus_fault_enable_o == $past(wdata_i[`HCS_BUS_ENA]))
    else $error("bus fault enable not taken from write");

  pend_write_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    wr_hcs && !pend_set[0] ##0 wdata_i[12] |=> pending_o[0])
    else $error("usage pending write lost");

  escalate_hard_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (data_access_violation_i && !memory_fault_enable_o) |=> hard_fault_o && !$past(mem_pend_set))
    else $error("disabled memory fault not escalated");

  status_view_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (req_i && !we_i && hit_status && size_i == SZ_BYTE && addr_i[1:0] == 2'h1)
    |=> rdata_o[31:16] == 16'h0000 && rdata_o[7:0] == 8'h00)
    else $error("bus byte view leaks other lanes");

  mem_valid_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    data_access_violation_i |=> mem_valid_q && memory_address_capture_o && mem_flags[1])
    else $error("memory address valid not set with capture");

  stack_nocap_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (memory_stacking_error_i && !data_access_violation_i)
    |=> mem_flags[`STK_BIT] && !memory_address_capture_o)
    else $error("stacking fault flag or capture wrong");

  bus_valid_clear_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (mem_evt && !sync_data_bus_error_i) |=> !bus_valid_q)
    else $error("memory fault did not clear bus address valid");

  fetch_issue_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (!bus_flags[0] && !(fetch_bus_error_i && fetch_issue_i)) |=> !bus_flags[0])
    else $error("fetch bus error flagged without issue");

  both_flags_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (async_data_bus_error_i ##1 !wr_status ##1 (sync_data_bus_error_i && !wr_status))
    |=> bus_flags[2] && bus_flags[1])
    else $error("async and precise flags not both held");

  sticky_hold_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (bus_flags[3] && !clr_bits[11]) |=> bus_flags[3])
    else $error("sticky flag dropped without clear");

  w1c_clear_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (clr_bits[4] && !memory_stacking_error_i) |=> !mem_flags[4])
    else $error("write one did not clear stacking flag");

  answer_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
    req_i |=> ack_o ##1 (ack_o == $past(req_i)))
    else $error("register answer timing wrong");
endmodule // system_fault_status_control

/* fault_source.sv */
`timescale 1ns/1ps
module fault_source (
  // Clock
  input  wire logic        clk_i,
  // Event pulses and priority level
  output logic      [44:0] ev_o,
  output logic             blk_o
);
  initial
  begin
    ev_o  = '0;
    blk_o = 1'b0;
  end

  // ==========================================================
  // Event pulse, one cycle, launched and dropped at falling edges
  task automatic pulse(input logic [44:0] v);
    @(negedge clk_i);
    ev_o = v;
    @(negedge clk_i);
    ev_o = '0;
  endtask

  // ==========================================================
  // Priority block level
  task automatic block(input logic b);
    @(negedge clk_i);
    blk_o = b;
  endtask
endmodule // fault_source

/* test_system_fault_status_control.sv */
`timescale 1ns/1ps
`include "fault_regs.svh"
module test_system_fault_status_control;
  import fault_pkg::*;
  logic           clk_i = 1'b0;
  logic           rstn_i = 1'b0;
  logic           req_i = 1'b0;
  logic           we_i = 1'b0;
  logic    [31:0] addr_i = '0;
  access_size_e   size_i = SZ_WORD;
  logic    [31:0] wdata_i = '0;
  logic    [31:0] rdata_o;
  logic           ack_o, err_o, ue, be, me, hard, mcap, bcap, blk;
  logic     [3:0] pend;
  logic     [6:0] act;
  logic    [44:0] ev;
  logic    [31:0] rd_q, saved;
  int             n_mismatch = 0;
  int             tests_run = 0;
  int             n_hard = 0;
  int             n_mcap = 0;
  int             n_bcap = 0;

  initial
  begin
    forever #2 clk_i = ~clk_i;
  end

  fault_source src (.clk_i(clk_i), .ev_o(ev), .blk_o(blk));

  system_fault_status_control dut (
    .clk_i(clk_i), .rstn_i(rstn_i), .req_i(req_i), .we_i(we_i), .addr_i(addr_i),
    .size_i(size_i), .wdata_i(wdata_i), .rdata_o(rdata_o), .ack_o(ack_o), .err_o(err_o),
    .memory_stacking_error_i(ev[0]), .memory_unstacking_error_i(ev[1]),
    .data_access_violation_i(ev[2]), .fetch_access_violation_i(ev[3]),
    .bus_stacking_error_i(ev[4]), .bus_unstacking_error_i(ev[5]),
    .async_data_bus_error_i(ev[6]), .sync_data_bus_error_i(ev[7]),
    .fetch_bus_error_i(ev[8]), .fetch_issue_i(ev[9]), .usage_cause_i(ev[25:10]),
    .prio_block_i(blk), .supervisor_call_pend_i(ev[26]), .pend_clr_i(ev[30:27]),
    .act_set_i(ev[37:31]), .act_clr_i(ev[44:38]),
    .usage_fault_enable_o(ue), .bus_fault_enable_o(be), .memory_fault_enable_o(me),
    .pending_o(pend), .active_o(act), .hard_fault_o(hard),
    .memory_address_capture_o(mcap), .bus_address_capture_o(bcap));

  // ==========================================================
  // Pulse counters
  always @(negedge clk_i)
  begin
    if (hard === 1'b1) n_hard++;
    if (mcap === 1'b1) n_mcap++;
    if (bcap === 1'b1) n_bcap++;
  end

  // ==========================================================
  // Tasks
  task automatic end_of_test;
    $display("Counts: %0d compared, %0d mismatched", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e)
    begin
      $display("BAD %s expected %h seen %h", n, e, g);
      n_mismatch++;
    end
  endtask

  task automatic xfer(input logic w, input logic [31:0] a, input access_size_e s,
                      input logic [31:0] d, input logic e);
    int i;
    @(negedge clk_i);
    req_i = 1'b1;
    we_i = w;
    addr_i = a;
    size_i = s;
    wdata_i = d;
    @(negedge clk_i);
    req_i = 1'b0;
    for (i = 0; i < 4 && ack_o !== 1'b1; i++) @(negedge clk_i);
    if (ack_o !== 1'b1)
    begin
      $display("BAD ack expected 1 seen %b", ack_o);
      n_mismatch++;
      end_of_test();
    end
    else
    begin
      rd_q = rdata_o;
      chk("err", {31'h0, e}, {31'h0, err_o});
    end
  endtask

  task automatic rd(input logic [31:0] a, input access_size_e s, input logic [31:0] e);
    xfer(1'b0, a, s, '0, 1'b0);
    chk("rdata", e, rd_q);
  endtask

  task automatic wr(input logic [31:0] a, input access_size_e s, input logic [31:0] d);
    xfer(1'b1, a, s, d, 1'b0);
  endtask

  task automatic ev1(input int b);
    src.pulse(45'(1) << b);
  endtask

  task automatic done(input string n);
    $display("test %s done", n);
  endtask

  // ==========================================================
  // Sequence
  initial
  begin
    repeat (4) @(negedge clk_i);
    rstn_i = 1'b1;
    rd(`HCS_ADDR, SZ_WORD, 32'h0);
    rd(`STATUS_ADDR, SZ_WORD, 32'h0);
    done("reset");

    wr(`HCS_ADDR, SZ_WORD, 32'hFFFFFFFF);
    rd(`HCS_ADDR, SZ_WORD, 32'h0007FD8B);
    chk("enables", 32'h7, {29'h0, ue, be, me});
    chk("pending", 32'hF, {28'h0, pend});
    chk("active", 32'h7F, {25'h0, act});
    wr(`HCS_ADDR, SZ_WORD, 32'h00070000);
    rd(`HCS_ADDR, SZ_WORD, 32'h00070000);
    wr(`HCS_ADDR, SZ_WORD, rd_q & ~32'h00040000);
    rd(`HCS_ADDR, SZ_WORD, 32'h00030000);
    chk("enables", 32'h3, {29'h0, ue, be, me});
    wr(`HCS_ADDR, SZ_WORD, rd_q | 32'h00040000);
    done("control");

    ev1(2);
    rd(`MEM_STATUS_ADDR, SZ_BYTE, 32'h82);
    chk("mem capture", 32'h1, n_mcap);
    rd(`HCS_ADDR, SZ_WORD, 32'h00072000);
    ev1(0);
    ev1(1);
    ev1(3);
    repeat (20) @(negedge clk_i);
    rd(`MEM_STATUS_ADDR, SZ_BYTE, 32'h9B);
    chk("mem capture", 32'h1, n_mcap);
    wr(`MEM_STATUS_ADDR, SZ_BYTE, 32'h02);
    rd(`MEM_STATUS_ADDR, SZ_BYTE, 32'h99);
    wr(`MEM_STATUS_ADDR, SZ_BYTE, 32'h80);
    rd(`MEM_STATUS_ADDR, SZ_BYTE, 32'h19);
    wr(`STATUS_ADDR, SZ_WORD, 32'hFFFFFFFF);
    rd(`STATUS_ADDR, SZ_WORD, 32'h0);
    wr(`HCS_ADDR, SZ_WORD, 32'h00070000);
    done("memory");

    ev1(7);
    rd(`BUS_STATUS_ADDR, SZ_BYTE, 32'h8200);
    chk("bus capture", 32'h1, n_bcap);
    ev1(0);
    rd(`STATUS_ADDR, SZ_HALF, 32'h0210);
    ev1(4);
    ev1(5);
    ev1(6);
    ev1(8);
    rd(`STATUS_ADDR, SZ_HALF, 32'h1E10);
    src.pulse(45'h300);
    rd(`STATUS_ADDR, SZ_HALF, 32'h1F10);
    chk("bus capture", 32'h1, n_bcap);
    wr(`STATUS_ADDR, SZ_WORD, 32'hFFFFFFFF);
    ev1(6);
    ev1(7);
    rd(`BUS_STATUS_ADDR, SZ_BYTE, 32'h8600);
    wr(`STATUS_ADDR, SZ_WORD, 32'hFFFFFFFF);
    wr(`HCS_ADDR, SZ_WORD, 32'h00070000);
    done("bus");

    src.block(1'b1);
    ev1(6);
    rd(`HCS_ADDR, SZ_WORD, 32'h00074000);
    chk("hard", 32'h0, n_hard);
    ev1(2);
    wr(`MEM_STATUS_ADDR, SZ_BYTE, 32'h80);
    chk("hard", 32'h1, n_hard);
    rd(`MEM_STATUS_ADDR, SZ_BYTE, 32'h02);
    src.block(1'b0);
    wr(`STATUS_ADDR, SZ_WORD, 32'hFFFFFFFF);
    wr(`HCS_ADDR, SZ_WORD, 32'h0);
    ev1(7);
    ev1(6);
    rd(`HCS_ADDR, SZ_WORD, 32'h0);
    chk("hard", 32'h3, n_hard);
    wr(`STATUS_ADDR, SZ_WORD, 32'hFFFFFFFF);
    done("escalation");

    src.pulse(45'hFFFF << 10);
    rd(`USE_STATUS_ADDR, SZ_HALF, 32'h030F0000);
    rd(`STATUS_ADDR + 32'h3, SZ_BYTE, 32'h03000000);
    xfer(1'b0, `BUS_STATUS_ADDR, SZ_HALF, '0, 1'b1);
    chk("rdata", 32'h0, rd_q);
    xfer(1'b0, 32'hE000ED30, SZ_WORD, '0, 1'b1);
    wr(`USE_STATUS_ADDR, SZ_HALF, 32'hFFFF0000);
    rd(`STATUS_ADDR, SZ_WORD, 32'h0);
    done("usage");

    src.pulse(45'h7F << 31);
    chk("active", 32'h7F, {25'h0, act});
    rd(`HCS_ADDR, SZ_WORD, 32'h00000D8B);
    saved = rd_q;
    wr(`HCS_ADDR, SZ_WORD, 32'h0);
    rd(`HCS_ADDR, SZ_WORD, 32'h0);
    wr(`HCS_ADDR, SZ_WORD, saved);
    rd(`HCS_ADDR, SZ_WORD, 32'h00000D8B);
    src.pulse(45'h7F << 38);
    chk("active", 32'h0, {25'h0, act});
    src.pulse(45'(1) << 26);
    chk("pending", 32'h8, {28'h0, pend});
    done("active");
    end_of_test();
  end
endmodule // test_system_fault_status_control
